/* File: logic/reset_combiner_pkg.sv */
/*
  Constants shared by the system reset combiner: clock rate, hold-off time,
  state codes and the layout of the reset cause vector.
  Assumes a single system clock at the rate given below.
*/
package reset_combiner_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  // minimum time the master reset stays high after the last source goes idle
  localparam int RESET_HOLD_NS = 400;
  localparam int RESET_HOLD_CYCLES_RAW = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_CYCLES_RAW < 1) ? 1 : RESET_HOLD_CYCLES_RAW;
  localparam int HOLD_CNT_W = 8;

  // ************************************************************
  // reset cause vector layout
  // ************************************************************
  localparam int CAUSE_W = 6;
  localparam int CAUSE_POWER_ON = 0;
  localparam int CAUSE_MASTER_CLEAR = 1;
  localparam int CAUSE_SOFTWARE = 2;
  localparam int CAUSE_WATCHDOG = 3;
  localparam int CAUSE_BROWNOUT = 4;
  localparam int CAUSE_CONFIG_MISMATCH = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET_VALUE = 6'h01;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;

endpackage

/* File: logic/system_reset_combiner.sv */
/*
  System reset combiner: merges power-on, master clear pin, software,
  watchdog, brown-out and configuration mismatch sources into one
  system master reset, records which sources fired, and latches entry
  into programming/debug operation when the master clear pin releases.
  Assumes: sys_rst_i is the power-on reset; the master clear pin, the
  programmer entry request and the brown-out detector come from outside
  the clock domain; software, watchdog and mismatch requests come from
  logic on clk_i and are themselves cleared by the master reset.
*/
// Summary of operation
// - a low level on the master clear pin puts the device into reset
// - all sources merge into one master reset output driven only here
// - six independent sources, any single one can cause the system reset
// - master clear pin resets, and enters programming and debug operation only when the entry request is held at its release
`timescale 1ns/1ps

module system_reset_combiner
  import reset_combiner_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic master_clear_pin_n_i,
  input wire logic debug_entry_req_i,
  input wire logic software_reset_source_i,
  input wire logic watchdog_reset_source_i,
  input wire logic brownout_reset_source_i,
  input wire logic config_mismatch_reset_source_i,
  input wire logic [CAUSE_W-1:0] cause_clear_i,
  output logic system_master_reset_o,
  output logic [CAUSE_W-1:0] reset_cause_o,
  output logic prog_debug_mode_o
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  // the master clear and brown-out synchronisers reset to the asserted level so that the
  // device never leaves power-on reset on a value not yet sampled
  logic master_clear_pin_meta_n;
  logic master_clear_pin_sync_n;
  logic master_clear_pin_prev_n;
  logic bor_meta;
  logic bor_sync;
  logic dbg_meta;
  logic dbg_sync;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      master_clear_pin_meta_n <= 1'b0;
      master_clear_pin_sync_n <= 1'b0;
    end
    else if (ce_i)
    begin
      master_clear_pin_meta_n <= master_clear_pin_n_i;
      master_clear_pin_sync_n <= master_clear_pin_meta_n;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bor_meta <= 1'b1;
      bor_sync <= 1'b1;
    end
    else if (ce_i)
    begin
      bor_meta <= brownout_reset_source_i;
      bor_sync <= bor_meta;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
    end
    else if (ce_i)
    begin
      dbg_meta <= debug_entry_req_i;
      dbg_sync <= dbg_meta;
    end
  end

  // delayed copy of the synchronised pin for release detection
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      master_clear_pin_prev_n <= 1'b0;
    end
    else if (ce_i)
    begin
      master_clear_pin_prev_n <= master_clear_pin_sync_n;
    end
  end

  // ************************************************************
  // source merge
  // ************************************************************
  logic [CAUSE_W-1:0] src_active;
  logic any_src;

  always_comb
  begin
    src_active = '0;
    src_active[CAUSE_MASTER_CLEAR] = ~master_clear_pin_sync_n;
    src_active[CAUSE_SOFTWARE] = software_reset_source_i;
    src_active[CAUSE_WATCHDOG] = watchdog_reset_source_i;
    src_active[CAUSE_BROWNOUT] = bor_sync;
    src_active[CAUSE_CONFIG_MISMATCH] = config_mismatch_reset_source_i;
    any_src = |src_active;
  end

  // ************************************************************
  // release sequencer
  // ************************************************************
  seq_state_t state;
  seq_state_t next_state;
  logic [HOLD_CNT_W-1:0] hold_cnt;
  logic hold_done;

  assign hold_done = (hold_cnt == HOLD_CNT_W'(HOLD_CYCLES - 1));

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:
      begin
        if (!any_src)
        begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (any_src)
        begin
          next_state = ST_RESET;
        end
        else if (hold_done)
        begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (any_src)
        begin
          next_state = ST_RESET;
        end
      end
      default:
      begin
        next_state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_RESET;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  // counter restarts whenever a source returns during the hold-off
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hold_cnt <= '0;
    end
    else if (ce_i)
    begin
      if (state == ST_HOLD && next_state == ST_HOLD)
      begin
        hold_cnt <= hold_cnt + HOLD_CNT_W'(1);
      end
      else
      begin
        hold_cnt <= '0;
      end
    end
  end

  // registered so that downstream flops never see a combinational glitch
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      system_master_reset_o <= 1'b1;
    end
    else if (ce_i)
    begin
      system_master_reset_o <= (next_state != ST_RUN);
    end
  end

  // ************************************************************
  // reset cause record
  // ************************************************************
  // a source active in the clearing cycle keeps its bit set
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reset_cause_o <= CAUSE_RESET_VALUE;
    end
    else if (ce_i)
    begin
      reset_cause_o <= (reset_cause_o & ~cause_clear_i) | src_active;
    end
  end

  // ************************************************************
  // programming and debug entry
  // ************************************************************
  // the tool holds master clear low itself and signals entry; the
  // choice is taken at pin release, a plain pin reset leaves the mode
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prog_debug_mode_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (master_clear_pin_sync_n && !master_clear_pin_prev_n)
      begin
        prog_debug_mode_o <= dbg_sync;
      end
    end
  end

endmodule

/* File: verification/reset_combiner_chk.sv */
/*
  Concurrent checks on the system reset combiner ports.
  Assumes one clock, sys_rst_i async high, bound from the testbench.
*/
`timescale 1ns/1ps
module reset_combiner_chk
  import reset_combiner_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic master_clear_pin_n_i,
  input wire logic debug_entry_req_i,
  input wire logic software_reset_source_i,
  input wire logic watchdog_reset_source_i,
  input wire logic system_master_reset_o,
  input wire logic [CAUSE_W-1:0] reset_cause_o,
  input wire logic prog_debug_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence pin_low_3;
    (!master_clear_pin_n_i && ce_i) [*3];
  endsequence
  sequence sw_idle_2;
    !$past(software_reset_source_i) && !$past(software_reset_source_i, 2);
  endsequence
  a_pin_low_resets: assert property (pin_low_3 |=> system_master_reset_o)
    else $error("low pin did not raise master reset");
  a_cause_has_reset: assert property ($rose(reset_cause_o[CAUSE_BROWNOUT]) |-> system_master_reset_o)
    else $error("cause set without master reset");
  a_sw_raises: assert property (ce_i && software_reset_source_i |=> system_master_reset_o && reset_cause_o[CAUSE_SOFTWARE])
    else $error("software request ignored");
  a_wdt_raises: assert property (ce_i && watchdog_reset_source_i |=> system_master_reset_o && reset_cause_o[CAUSE_WATCHDOG])
    else $error("watchdog expiry ignored");
  a_debug_entry_req: assert property ($rose(prog_debug_mode_o) |-> master_clear_pin_n_i && $past(debug_entry_req_i, 3))
    else $error("debug mode without request");
  a_release_idle: assert property ($fell(system_master_reset_o) |-> sw_idle_2)
    else $error("master reset released while source active");
endmodule

/* File: verification/clear_pin_tool.sv */
/*
  Model of the programmer or reset circuit on the master clear pin.
  Assumes go_i is driven off the falling edge and held one cycle.
*/
`timescale 1ns/1ps
module clear_pin_tool
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic dbg_i,
  output logic pin_n_o,
  output logic req_o
);
  initial
  begin
    pin_n_o = 1'b1;
    req_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        @(negedge clk_i);
        // request held across the release so it is seen synchronised
        req_o = dbg_i;
        pin_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        pin_n_o = 1'b1;
        repeat (8) @(negedge clk_i);
        req_o = 1'b0;
      end
    end
  end
endmodule

/* File: verification/testbench.sv */
/*
  Self-checking bench for the system reset combiner.
  Assumes HOLD_CYCLES set to 2 so hold-off counts stay short.
*/
`timescale 1ns/1ps
module testbench;
  import reset_combiner_pkg::*;
  localparam int HOLD = 2;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic brownout_reset_source_i = 1'b0;
  logic go = 1'b0;
  logic dbg = 1'b0;
  logic [2:0] src = 3'h0;
  logic [CAUSE_W-1:0] cause_clear_i = 6'h00;
  logic master_clear_pin_n_i, debug_entry_req_i, system_master_reset_o, prog_debug_mode_o;
  logic [CAUSE_W-1:0] reset_cause_o;
  int mismatches = 0;
  int total_checks = 0;
  int seed = 93;
  int exp_cause, n, quiet;
  int map[$] = '{CAUSE_SOFTWARE, CAUSE_WATCHDOG, CAUSE_CONFIG_MISMATCH};
  system_reset_combiner #(.HOLD_CYCLES(HOLD)) uut (.clk_i, .sys_rst_i, .ce_i,
    .master_clear_pin_n_i, .debug_entry_req_i, .software_reset_source_i(src[0]),
    .watchdog_reset_source_i(src[1]), .brownout_reset_source_i,
    .config_mismatch_reset_source_i(src[2]), .cause_clear_i, .system_master_reset_o,
    .reset_cause_o, .prog_debug_mode_o);
  clear_pin_tool tool (.clk_i, .go_i(go), .dbg_i(dbg), .pin_n_o(master_clear_pin_n_i),
    .req_o(debug_entry_req_i));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for release, n counts falling edges
  task run_wait;
    n = 0;
    while (system_master_reset_o !== 1'b0 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task cause_is;
    chk({2'b00, reset_cause_o}, exp_cause[7:0]);
    cause_clear_i = 6'h3F;
    @(negedge clk_i);
    cause_clear_i = 6'h00;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (10) @(negedge clk_i);
    chk({system_master_reset_o, prog_debug_mode_o, reset_cause_o}, 8'h81);
    sys_rst_i = 1'b0;
    run_wait;
    exp_cause = 'h13;
    cause_is;
    foreach (map[i])
    begin
      src = 3'h1 << i;
      @(negedge clk_i);
      src = 3'h0;
      chk({7'h00, system_master_reset_o}, 8'h01);
      run_wait;
      chk(n[7:0], HOLD + 1);
      exp_cause = 1 << map[i];
      cause_is;
    end
    // pulses inside the hold-off restart the count each time;
    // quiet counts idle cycles since the last request, reset stands while quiet <= HOLD
    exp_cause = 0;
    quiet = HOLD + 1;
    repeat (6)
    begin
      src = 3'($random(seed));
      foreach (map[i]) if (src[i]) exp_cause |= 1 << map[i];
      quiet = (src != 3'h0) ? 0 : quiet + 1;
      @(negedge clk_i);
      src = 3'h0;
      chk({7'h00, system_master_reset_o}, {7'h00, quiet <= HOLD});
    end
    run_wait;
    chk(n[7:0], quiet <= HOLD ? HOLD + 1 - quiet : 0);
    cause_is;
    // a frozen block ignores a request entirely
    ce_i = 1'b0;
    src = 3'h1;
    @(negedge clk_i);
    src = 3'h0;
    @(negedge clk_i);
    chk({7'h00, system_master_reset_o}, 8'h00);
    chk({2'b00, reset_cause_o}, 8'h00);
    ce_i = 1'b1;
    // a request in the clearing cycle keeps its cause bit
    src = 3'h1;
    cause_clear_i = 6'h3F;
    @(negedge clk_i);
    src = 3'h0;
    cause_clear_i = 6'h00;
    chk({7'h00, system_master_reset_o}, 8'h01);
    run_wait;
    exp_cause = 1 << CAUSE_SOFTWARE;
    cause_is;
    brownout_reset_source_i = 1'b1;
    repeat (3) @(negedge clk_i);
    brownout_reset_source_i = 1'b0;
    chk({7'h00, system_master_reset_o}, 8'h01);
    run_wait;
    exp_cause = 'h10;
    cause_is;
    for (int d = 1; d >= 0; d--)
    begin
      dbg = d[0];
      go = 1'b1;
      @(negedge clk_i);
      go = 1'b0;
      repeat (5) @(negedge clk_i);
      chk({7'h00, system_master_reset_o}, 8'h01);
      repeat (20) @(negedge clk_i);
      chk({7'h00, prog_debug_mode_o}, {7'h00, dbg});
      exp_cause = 'h02;
      cause_is;
    end
    test_done;
  end
endmodule
bind system_reset_combiner reset_combiner_chk chk_i (.clk_i, .sys_rst_i, .ce_i,
  .master_clear_pin_n_i, .debug_entry_req_i, .software_reset_source_i,
  .watchdog_reset_source_i, .system_master_reset_o, .reset_cause_o, .prog_debug_mode_o);
